// ---- logic/phy_interrupt_manager.sv ----
// Summary of operation
// - irq_out_n low while any enabled source flag is set.
// - two release modes, primary and alternative; assertion identical.
// - alt_irq_select zero selects primary; forced zero at hard reset.
// - mask bit n pairs with flag bit n, sources seven down to one.
// - flags set on rising status edges; link down on link falling edge.
// - primary releases on status fall or flag read; special register 1 cases.
// - fault and page also released by register 6 read, restart, link loss.
// - energy released while high gives 256 ms pulse one second after drop.
// - energy flag reads one at power-up, stays set with energy absent until released.
// - alternative mode: clearing pending mask bit releases irq_out_n at once.
// - alternative mode: writing one to a flag tests its release condition.
// - condition true: flag clears and output releases together.
// - condition false: flag stays set and output stays asserted.
// - condition is status low; link down condition is link high.
// - mask bits seven to zero read-write, reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "irq_mgr_defines.svh"
module phy_interrupt_manager #(
	parameter int unsigned DELAY_CYC = `ENERGY_DELAY_CYC,
	parameter int unsigned PULSE_CYC = `ENERGY_PULSE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        alt_irq_select,
	input  wire logic        line_energy_present,
	input  wire logic        an_complete,
	input  wire logic        remote_fault,
	input  wire logic        link_status,
	input  wire logic        partner_ack,
	input  wire logic        par_det_fault,
	input  wire logic        page_received,
	input  wire logic        an_restart,
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             irq_out_n
);
	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ************************************************************
	// source levels and edges
	// ************************************************************
	logic [7:0] level;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] set_ev;
	logic [7:0] status_low;

	// link down source is carried inverted so it behaves like the rest
	assign level = {line_energy_present, an_complete, remote_fault, ~link_status,
		partner_ack, par_det_fault, page_received, 1'b0};

	edge_detect u_edge (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.level_in (level),
		.rise     (rise),
		.fall     (fall)
	);

	assign set_ev     = rise & 8'hfe;
	assign status_low = ~level & 8'hfe;

	// ************************************************************
	// register state
	// ************************************************************
	typedef struct packed {
		logic [7:0]  mask;
		logic [7:0]  flags;
		logic        energy_init;
		logic [15:0] rdata;
	} mgr_state_type;

	mgr_state_type s_q;
	mgr_state_type s_d;

	logic       wr_mask;
	logic       wr_flags;
	logic       rd_flags;
	logic       rd_status;
	logic       rd_expansion;
	logic [7:0] clr;
	logic       energy_pulse;
	logic       energy_rel_high;

	assign wr_mask      = reg_wr && (reg_addr == `REG_IRQ_MASK);
	assign wr_flags     = reg_wr && (reg_addr == `REG_SRC_FLAGS);
	assign rd_flags     = reg_rd && (reg_addr == `REG_SRC_FLAGS);
	assign rd_status    = reg_rd && (reg_addr == `REG_BASIC_STATUS);
	assign rd_expansion = reg_rd && (reg_addr == `REG_AN_EXPANSION);

	function automatic logic [7:0] primary_clear(
		input logic [7:0] falls,
		input logic       flag_rd,
		input logic       stat_rd,
		input logic       exp_rd,
		input logic       restart,
		input logic       link_loss
	);
		logic [7:0] c;
		c = falls;
		c[`SRC_LINK_DOWN] = 1'b0;
		c[`SRC_REMOTE_FAULT] = c[`SRC_REMOTE_FAULT] | stat_rd;
		c[`SRC_LINK_DOWN] = stat_rd;
		if (exp_rd || restart || link_loss) begin
			c[`SRC_PAR_DET_FAULT] = 1'b1;
			c[`SRC_PAGE_RX] = 1'b1;
		end
		if (flag_rd) begin
			c = 8'hfe;
		end
		return c;
	endfunction

	always_comb begin
		s_d = s_q;
		clr = 8'h00;
		if (alt_irq_select) begin
			if (wr_flags) begin
				clr = reg_wdata[7:0] & status_low;
			end
		end else begin
			clr = primary_clear(fall, rd_flags, rd_status, rd_expansion,
				an_restart, fall[`SRC_LINK_DOWN] == 1'b0 && rise[`SRC_LINK_DOWN]);
		end
		if (clk_en) begin
			// set wins over a clear in the same cycle
			s_d.flags = ((s_q.flags & ~clr) | set_ev) & 8'hfe;
			if (s_q.energy_init) begin
				s_d.flags[`SRC_ENERGY] = 1'b1;
				s_d.energy_init = 1'b0;
			end
			if (wr_mask) begin
				s_d.mask = reg_wdata[7:0];
			end
			if (reg_rd) begin
				case (reg_addr)
					`REG_SRC_FLAGS: s_d.rdata = {8'h00, s_q.flags};
					`REG_IRQ_MASK:  s_d.rdata = {8'h00, s_q.mask};
					default:        s_d.rdata = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{mask: `MASK_RESET, flags: `FLAGS_RESET, energy_init: 1'b1, rdata: 16'h0000};
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// energy late pulse
	// ************************************************************
	// a flag read can release energy while it is still present
	assign energy_rel_high = !alt_irq_select && rd_flags && s_q.flags[`SRC_ENERGY]
		&& line_energy_present;

	energy_timer #(
		.DELAY_CYC (DELAY_CYC),
		.PULSE_CYC (PULSE_CYC)
	) u_energy (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.enabled       (s_q.mask[`SRC_ENERGY]),
		.released_high (energy_rel_high),
		.energy_fall   (fall[`SRC_ENERGY]),
		.pulse         (energy_pulse)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	assign reg_rdata = s_q.rdata;
	// combinational from flags and mask: clearing a mask bit releases at once
	assign irq_out_n = ~(|(s_q.flags & s_q.mask) | energy_pulse);
endmodule // phy_interrupt_manager
`default_nettype wire

// ---- logic/irq_mgr_defines.svh ----
`ifndef IRQ_MGR_DEFINES_SVH
`define IRQ_MGR_DEFINES_SVH

`define REG_SRC_FLAGS      5'h1d
`define REG_IRQ_MASK       5'h1e
`define REG_BASIC_STATUS   5'h01
`define REG_AN_EXPANSION   5'h06
`define MASK_RESET         8'h00
`define FLAGS_RESET        8'h00
`define SRC_ENERGY         7
`define SRC_AN_DONE        6
`define SRC_REMOTE_FAULT   5
`define SRC_LINK_DOWN      4
`define SRC_PARTNER_ACK    3
`define SRC_PAR_DET_FAULT  2
`define SRC_PAGE_RX        1
`define CLK_FREQ_HZ        50000000
`define ENERGY_DELAY_MS    1000
`define ENERGY_PULSE_MS    256
`define ENERGY_DELAY_CYC   (`CLK_FREQ_HZ / 1000 * `ENERGY_DELAY_MS)
`define ENERGY_PULSE_CYC   (`CLK_FREQ_HZ / 1000 * `ENERGY_PULSE_MS)

`endif

// ---- logic/irq_mgr_pkg.sv ----
`default_nettype none
package irq_mgr_pkg;
	typedef enum logic [1:0] {
		ep_idle,
		ep_armed,
		ep_wait,
		ep_pulse
	} energy_state_type;
endpackage
`default_nettype wire

// ---- logic/edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] level_in,
	output logic      [7:0] rise,
	output logic      [7:0] fall
);
	typedef struct packed {
		logic [7:0] prev;
	} edge_state_type;

	edge_state_type s_q;
	edge_state_type s_d;

	always_comb begin
		s_d = s_q;
		if (clk_en) begin
			s_d.prev = level_in;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// gated by the enable so a frozen clock sees no edge
	assign rise = clk_en ? (level_in & ~s_q.prev) : 8'h00;
	assign fall = clk_en ? (~level_in & s_q.prev) : 8'h00;
endmodule // edge_detect
`default_nettype wire

// ---- logic/energy_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_mgr_defines.svh"
module energy_timer #(
	parameter int unsigned DELAY_CYC = `ENERGY_DELAY_CYC,
	parameter int unsigned PULSE_CYC = `ENERGY_PULSE_CYC
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic enabled,
	input  wire logic released_high,
	input  wire logic energy_fall,
	output logic      pulse
);
	typedef struct packed {
		irq_mgr_pkg::energy_state_type st;
		logic [31:0]                   cnt;
	} timer_state_type;

	timer_state_type s_q;
	timer_state_type s_d;

	always_comb begin
		s_d = s_q;
		if (clk_en) begin
			case (s_q.st)
				irq_mgr_pkg::ep_idle: begin
					if (released_high && enabled) begin
						s_d.st = irq_mgr_pkg::ep_armed;
					end
				end
				irq_mgr_pkg::ep_armed: begin
					if (!enabled) begin
						s_d.st = irq_mgr_pkg::ep_idle;
					end else if (energy_fall) begin
						s_d.st  = irq_mgr_pkg::ep_wait;
						s_d.cnt = 32'h0;
					end
				end
				irq_mgr_pkg::ep_wait: begin
					if (!enabled) begin
						s_d.st = irq_mgr_pkg::ep_idle;
					end else if (s_q.cnt >= DELAY_CYC - 1) begin
						s_d.st  = irq_mgr_pkg::ep_pulse;
						s_d.cnt = 32'h0;
					end else begin
						s_d.cnt = s_q.cnt + 32'h1;
					end
				end
				irq_mgr_pkg::ep_pulse: begin
					if (!enabled || s_q.cnt >= PULSE_CYC - 1) begin
						s_d.st = irq_mgr_pkg::ep_idle;
					end else begin
						s_d.cnt = s_q.cnt + 32'h1;
					end
				end
				default: s_d.st = irq_mgr_pkg::ep_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: irq_mgr_pkg::ep_idle, cnt: 32'h0};
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse = (s_q.st == irq_mgr_pkg::ep_pulse);
endmodule // energy_timer
`default_nettype wire

// ---- dv/irq_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// host mode holder
// ****
module irq_host_model (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic want_alt,
	output logic      alt_irq_select
);
	// lost on hard reset, host asks again
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) alt_irq_select <= 1'h0;
		else if (want_alt) alt_irq_select <= 1'h1;
	end
endmodule // irq_host_model
`default_nettype wire

// ---- dv/irq_mgr_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module irq_mgr_asserts (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        alt_irq_select,
	input wire logic        an_complete,
	input wire logic        link_status,
	input wire logic [6:0]  st,
	input wire logic [4:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        irq_out_n
);
	logic [7:0] mask_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) mask_q <= 8'h00;
		else if (reg_wr && reg_addr == 5'h1e) mask_q <= reg_wdata[7:0];
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_quiet; mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> irq_out_n; endproperty
	a_quiet: assert property (p_quiet) else $error("irq while masked");
	property p_unmask; reg_wr && reg_addr == 5'h1e && reg_wdata[7:0] == 8'h00 |-> ##[1:2] irq_out_n; endproperty
	a_unmask: assert property (p_unmask) else $error("irq kept after unmask");
	property p_flag_rd; reg_rd && reg_addr == 5'h1d |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[0]; endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("flag spare bits set");
	property p_mask_rd; reg_rd && reg_addr == 5'h1e |=> reg_rdata == {8'h00, $past(mask_q)}; endproperty
	a_mask_rd: assert property (p_mask_rd) else $error("mask readback");
	// quiet sources so no set event races the read
	property p_prim_clr; !alt_irq_select && $stable(st) ##1 reg_rd && !reg_wr && reg_addr == 5'h1d && $stable(st)
		##1 $stable(st) |-> ##[0:1] irq_out_n; endproperty
	a_prim_clr: assert property (p_prim_clr) else $error("read kept irq");
	property p_link; !alt_irq_select && mask_q[4] && $fell(link_status) ##1 (!reg_rd && !reg_wr) [*2]
		|-> ##[0:1] !irq_out_n; endproperty
	a_link: assert property (p_link) else $error("link loss missed");
	property p_alt_clr; alt_irq_select && mask_q == 8'h40 && reg_wr && reg_addr == 5'h1d && reg_wdata[6]
		&& !an_complete ##1 !an_complete && !reg_wr |-> ##[0:1] irq_out_n; endproperty
	a_alt_clr: assert property (p_alt_clr) else $error("flag write kept irq");
	property p_alt_keep; alt_irq_select && mask_q == 8'h40 && !irq_out_n && reg_wr && reg_addr == 5'h1d
		&& an_complete ##1 !reg_wr |=> !irq_out_n; endproperty
	a_alt_keep: assert property (p_alt_keep) else $error("flag write dropped irq");
endmodule // irq_mgr_asserts
bind phy_interrupt_manager irq_mgr_asserts i_irq_mgr_asserts (.sys_clk(sys_clk), .nrst(nrst),
	.alt_irq_select(alt_irq_select), .an_complete(an_complete), .link_status(link_status),
	.st({line_energy_present, an_complete, remote_fault, link_status, partner_ack, par_det_fault, page_received}),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.irq_out_n(irq_out_n));
`default_nettype wire

// ---- dv/phy_interrupt_manager_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
// ****
// bench
// ****
module phy_interrupt_manager_tb;
	typedef struct packed {logic [2:0] n; logic [4:0] a; logic [15:0] d;} row_type;
	localparam int DLY = 20;
	logic        sys_clk = 1'h0, nrst = 1'h0, rst_r = 1'h0, reg_rd = 1'h0, reg_wr = 1'h0, want_alt = 1'h0;
	logic [7:1]  src = 7'h40;
	logic        en = 1'h1;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	wire logic [15:0] reg_rdata;
	wire logic   irq_out_n, alt_irq_select;
	int          n_mismatch = 0, total_checks = 0, cyc = 0;
	row_type rows [6] = '{'{3'h6, 5'h1d, 16'h0040}, '{3'h5, 5'h01, 16'h0}, '{3'h4, 5'h01, 16'h0},
		'{3'h3, 5'h1d, 16'h0008}, '{3'h2, 5'h06, 16'h0}, '{3'h1, 5'h06, 16'h0}};
	initial forever #10 sys_clk = ~sys_clk;
	irq_host_model i_irq_host_model (.sys_clk(sys_clk), .nrst(nrst), .want_alt(want_alt),
		.alt_irq_select(alt_irq_select));
	phy_interrupt_manager #(.DELAY_CYC(DLY), .PULSE_CYC(8)) i_phy_interrupt_manager (.sys_clk(sys_clk),
		.nrst(nrst), .clk_en(en), .alt_irq_select(alt_irq_select), .line_energy_present(src[7]),
		.an_complete(src[6]), .remote_fault(src[5]), .link_status(~src[4]), .partner_ack(src[3]),
		.par_det_fault(src[2]), .page_received(src[1]), .an_restart(rst_r), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= ~w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		tick(1);
	endtask
	task automatic put(input int k, input logic v);
		@(posedge sys_clk);
		src[k] <= v;
		tick(3);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ceiling well above the few hundred cycles used
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'h1;
		tick(6);
		acc(0, 5'h1d, 16'h0);
		`CHK("flags", 16'h0080, reg_rdata)
		acc(1, 5'h1e, 16'hffff);
		acc(0, 5'h1e, 16'h0);
		`CHK("mask", 16'h00ff, reg_rdata)
		for (int i = 0; i < 6; i++) begin
			acc(1, 5'h1e, 16'h1 << rows[i].n);
			put(rows[i].n, 1'h1);
			`CHK("irq", 1'h0, irq_out_n)
			acc(0, rows[i].a, 16'h0);
			`CHK("rdata", rows[i].d, reg_rdata)
			`CHK("irq rel", 1'h1, irq_out_n)
			put(rows[i].n, 1'h0);
		end
		acc(1, 5'h1e, 16'h0006);
		put(1, 1'h1);
		`CHK("page set", 1'h0, irq_out_n)
		@(posedge sys_clk) rst_r <= 1'h1;
		@(posedge sys_clk) rst_r <= 1'h0;
		tick(1);
		`CHK("restart", 1'h1, irq_out_n)
		put(1, 1'h0);
		put(2, 1'h1);
		`CHK("fault set", 1'h0, irq_out_n)
		put(4, 1'h1);
		`CHK("link loss", 1'h1, irq_out_n)
		acc(0, 5'h1d, 16'h0);
		`CHK("link flag", 16'h0010, reg_rdata)
		put(4, 1'h0);
		put(2, 1'h0);
		acc(1, 5'h1e, 16'h0080);
		put(7, 1'h0);
		put(7, 1'h1);
		`CHK("energy", 1'h0, irq_out_n)
		put(7, 1'h0);
		`CHK("energy off", 1'h1, irq_out_n)
		put(7, 1'h1);
		acc(0, 5'h1d, 16'h0);
		`CHK("energy rd", 16'h0080, reg_rdata)
		put(7, 1'h0);
		tick(7);
		`CHK("delay", 1'h1, irq_out_n)
		tick(DLY - 5);
		`CHK("pulse", 1'h0, irq_out_n)
		tick(15);
		`CHK("pulse end", 1'h1, irq_out_n)
		acc(1, 5'h1e, 16'h0);
		@(posedge sys_clk) want_alt <= 1'h1;
		@(posedge sys_clk) want_alt <= 1'h0;
		acc(1, 5'h1e, 16'h0040);
		put(6, 1'h1);
		`CHK("alt set", 1'h0, irq_out_n)
		acc(1, 5'h1d, 16'h0040);
		`CHK("alt keep", 1'h0, irq_out_n)
		put(6, 1'h0);
		acc(0, 5'h1d, 16'h0);
		`CHK("alt hold", 16'h0040, reg_rdata)
		acc(1, 5'h1d, 16'h0040);
		`CHK("alt clr", 1'h1, irq_out_n)
		put(6, 1'h1);
		`CHK("alt again", 1'h0, irq_out_n)
		acc(1, 5'h1e, 16'h0);
		`CHK("alt mask", 1'h1, irq_out_n)
		@(posedge sys_clk) nrst <= 1'h0;
		tick(2);
		`CHK("rst irq", 1'h1, irq_out_n)
		@(posedge sys_clk) nrst <= 1'h1;
		tick(6);
		acc(0, 5'h1e, 16'h0);
		`CHK("rst mask", 16'h0, reg_rdata)
		acc(1, 5'h1e, 16'h0040);
		put(6, 1'h0);
		put(6, 1'h1);
		acc(0, 5'h1d, 16'h0);
		`CHK("primary", 1'h1, irq_out_n)
		@(posedge sys_clk) en <= 1'h0;
		put(6, 1'h0);
		put(6, 1'h1);
		@(posedge sys_clk) en <= 1'h1;
		tick(2);
		`CHK("frozen", 1'h1, irq_out_n)
		stop_test();
	end
endmodule // phy_interrupt_manager_tb
`default_nettype wire
